// ### rtl/csc_ctrl.v
`timescale 1ns/1ns
`default_nettype none
`include "csc_regs.vh"

module csc_ctrl #(
   parameter [31:0] SEC_CYCLES = `CSC_CLK_HZ / `CSC_FLASH_HZ,
   parameter [31:0] PULSE_CYCLES = `CSC_TRICKLE_PULSE_US * `CSC_CLK_MHZ,
   parameter [`CSC_TMR_W-1:0] RC_US = `CSC_RC_US,
   parameter [`CSC_TMR_W-1:0] MTO_CYCLES = 48'h2 * RC_US * `CSC_MTO_SCALE * `CSC_CLK_MHZ
) (
   input wire sys_clk, // System clock, 50 MHz
   input wire rst, // Synchronous reset, active high
   input wire chem_lithium, // Pack chemistry is lithium
   input wire cell_above_sleep, // Cell voltage above sleep_threshold
   input wire cell_above_mcv, // Cell voltage above max_cell_voltage
   input wire cell_below_lbat, // Cell voltage below precharge_min_voltage
   input wire current_over_limit, // Sensed current above fast-charge limit
   input wire current_below_min, // Sensed current below limit / 14
   input wire temp_cutoff, // Thermistor beyond temp_cutoff
   input wire hot_fault, // Thermistor beyond hot_fault
   input wire cold_fault, // Thermistor beyond cold_fault
   input wire temp_rise_detect, // Rate-of-rise limit seen by evaluator
   output reg status_lamp_out, // Open-drain lamp data, always low
   output reg status_lamp_oe, // Lamp pulled low while high
   output reg switch_drive_out, // Switching-drive output
   output reg timer_program_out, // Timer-program pin data, always low
   output reg timer_program_oe, // Timer pin grounded while high
   output reg temp_sample_out, // One-cycle temperature sample strobe
   output reg [`CSC_ST_W-1:0] charge_state // Current charge state
);
   localparam [`CSC_PROBE_CNT_W-1:0] PROBE_LAST =
      `CSC_PROBE_PULSES * `CSC_PROBE_PERIOD - 1;
   localparam [`CSC_PROBE_CNT_W-1:0] PROBE_MASK = `CSC_PROBE_PERIOD - 1;
   localparam [`CSC_PROBE_CNT_W-1:0] PROBE_WIDTH = `CSC_PROBE_WIDTH;

   reg [`CSC_ST_W-1:0] next_state;
   reg suspended;
   reg next_suspended;
   reg [`CSC_PROBE_CNT_W-1:0] probe_cnt;
   reg rise_seen;
   reg next_drive;
   reg next_lamp_oe;
   wire flash;
   wire trickle_on;
   wire sample_tick;
   wire holdoff_done;
   wire expired;
   wire osc_run;
   wire timer_clear;
   wire timer_run;
   wire probe_done;
   wire stop_any;

   // Lamp mode of a state; the one-hot code keeps the mapping unique
   function [1:0] lamp_mode;
      input [`CSC_ST_W-1:0] st;
      begin
         case (st)
            `CSC_ST_QUAL: lamp_mode = `CSC_LAMP_FLASH;
            `CSC_ST_FAST: lamp_mode = `CSC_LAMP_LOW;
            `CSC_ST_MAINT: lamp_mode = `CSC_LAMP_LOW;
            `CSC_ST_PROBE: lamp_mode = `CSC_LAMP_HIZ;
            default: lamp_mode = `CSC_LAMP_HIZ;
         endcase
      end
   endfunction

   // Oscillator halts in sleep, so the flash phase restarts on waking
   assign osc_run = (charge_state != `CSC_ST_SLEEP);
   assign timer_run = (charge_state == `CSC_ST_FAST);
   assign timer_clear = (charge_state == `CSC_ST_QUAL) &&
                        (next_state == `CSC_ST_FAST) && !suspended;
   assign probe_done = (probe_cnt == PROBE_LAST);
   assign stop_any = temp_cutoff || hot_fault;

   csc_timebase #(
      .SEC_CYCLES(SEC_CYCLES),
      .PULSE_CYCLES(PULSE_CYCLES),
      .SAMPLE_SECS(5'h10)
   ) u_timebase (
      .sys_clk(sys_clk),
      .rst(rst),
      .run(osc_run),
      .flash(flash),
      .trickle_on(trickle_on),
      .sample_tick(sample_tick)
   );

   csc_timer #(
      .MTO_CYCLES(MTO_CYCLES)
   ) u_timer (
      .sys_clk(sys_clk),
      .rst(rst),
      .clear(timer_clear),
      .run(timer_run),
      .holdoff_done(holdoff_done),
      .expired(expired)
   );

   // Charge-state transitions; sleep entry overrides every state
   always @* begin
      next_state = charge_state;
      next_suspended = suspended;
      case (charge_state)
         `CSC_ST_QUAL: begin
            if (stop_any) begin
               next_state = `CSC_ST_DONE;
               next_suspended = 1'b0;
            end else if (cell_above_mcv) begin
               next_state = `CSC_ST_ABSENT;
               next_suspended = 1'b0;
            end else if (!cold_fault && !cell_below_lbat) begin
               next_state = `CSC_ST_FAST;
            end
         end
         `CSC_ST_FAST: begin
            next_suspended = 1'b0;
            if (temp_cutoff) begin
               next_state = `CSC_ST_DONE;
            end else if (expired) begin
               next_state = `CSC_ST_DONE;
            end else if (cold_fault) begin
               next_state = `CSC_ST_QUAL;
               next_suspended = 1'b1;
            end else if (chem_lithium && holdoff_done && current_below_min) begin
               next_state = `CSC_ST_DONE;
            end else if (!chem_lithium && holdoff_done && rise_seen) begin
               next_state = `CSC_ST_MAINT;
            end
         end
         `CSC_ST_MAINT: begin
            if (stop_any || chem_lithium) begin
               next_state = `CSC_ST_DONE;
            end
         end
         `CSC_ST_DONE: begin
            next_state = `CSC_ST_DONE;
         end
         `CSC_ST_ABSENT: begin
            if (!cell_above_mcv) begin
               next_state = `CSC_ST_QUAL;
            end
         end
         `CSC_ST_SLEEP: begin
            next_suspended = 1'b0;
            if (!cell_above_mcv) begin
               next_state = `CSC_ST_PROBE;
            end
         end
         `CSC_ST_PROBE: begin
            if (probe_done) begin
               next_state = `CSC_ST_QUAL;
            end
         end
         default: begin
            next_state = `CSC_ST_QUAL;
            next_suspended = 1'b0;
         end
      endcase
      if (cell_above_sleep) begin
         next_state = `CSC_ST_SLEEP;
         next_suspended = 1'b0;
      end
   end

   // Drive and lamp follow the next state so a fault is seen the same edge
   always @* begin
      next_drive = 1'b0;
      case (next_state)
         `CSC_ST_QUAL: begin
            next_drive = trickle_on;
         end
         `CSC_ST_FAST: begin
            next_drive = !current_over_limit && !cell_above_mcv;
         end
         `CSC_ST_MAINT: begin
            next_drive = trickle_on && !chem_lithium;
         end
         `CSC_ST_PROBE: begin
            next_drive = ((probe_cnt & PROBE_MASK) < PROBE_WIDTH);
         end
         `CSC_ST_SLEEP: begin
            next_drive = 1'b0;
         end
         default: begin
            next_drive = 1'b0;
         end
      endcase
      case (lamp_mode(next_state))
         `CSC_LAMP_FLASH: next_lamp_oe = flash;
         `CSC_LAMP_LOW: next_lamp_oe = 1'b1;
         default: next_lamp_oe = 1'b0;
      endcase
   end

   // State, suspend flag and the wake-up probe counter
   always @(posedge sys_clk) begin
      if (rst) begin
         charge_state <= `CSC_ST_QUAL;
         suspended <= 1'b0;
         probe_cnt <= {`CSC_PROBE_CNT_W{1'b0}};
      end else begin
         charge_state <= next_state;
         suspended <= next_suspended;
         if (charge_state == `CSC_ST_PROBE && !probe_done) begin
            probe_cnt <= probe_cnt + 7'h01;
         end else if (charge_state != `CSC_ST_PROBE) begin
            probe_cnt <= {`CSC_PROBE_CNT_W{1'b0}};
         end
      end
   end

   // Rate-of-rise verdict is only taken at a sample point, not continuously
   always @(posedge sys_clk) begin
      if (rst) begin
         rise_seen <= 1'b0;
         temp_sample_out <= 1'b0;
      end else begin
         temp_sample_out <= sample_tick && timer_run && !chem_lithium;
         if (!timer_run) begin
            rise_seen <= 1'b0;
         end else if (sample_tick) begin
            rise_seen <= temp_rise_detect;
         end
      end
   end

   // Pin outputs; open-drain data stays low, only the enables and the switching drive move
   always @(posedge sys_clk) begin
      if (rst) begin
         status_lamp_out <= 1'b0;
         status_lamp_oe <= 1'b0;
         switch_drive_out <= 1'b0;
         timer_program_out <= 1'b0;
         timer_program_oe <= 1'b0;
      end else begin
         status_lamp_out <= 1'b0;
         status_lamp_oe <= next_lamp_oe;
         switch_drive_out <= next_drive;
         timer_program_out <= 1'b0;
         timer_program_oe <= (next_state == `CSC_ST_SLEEP);
      end
   end
endmodule

`default_nettype wire

// ### rtl/csc_regs.vh
`ifndef CSC_REGS_VH
`define CSC_REGS_VH

// System clock
`define CSC_CLK_HZ 50000000
`define CSC_CLK_MHZ 50

// Lamp flash and trickle pulse rate, in hertz
`define CSC_FLASH_HZ 1
// Trickle pulse width, in microseconds
`define CSC_TRICKLE_PULSE_US 10000
// Temperature sampling interval for rate-of-rise, in seconds
`define CSC_SAMPLE_S 16

// Timer-program resistor times capacitor, in microseconds
`define CSC_RC_US 1000
// Scale of the resistor-capacitor product into the charge timeout
`define CSC_MTO_SCALE 35988
// Hold-off is the timeout divided by this
`define CSC_HOLDOFF_DIV 32
// Minimum-current divisor, applied by the external current comparator
`define CSC_MIN_CUR_DIV 14

// Wake-up probe pulses on the switching drive
`define CSC_PROBE_PULSES 3
`define CSC_PROBE_PERIOD 32
`define CSC_PROBE_WIDTH 8
`define CSC_PROBE_CNT_W 7

// Charge states, one-hot
`define CSC_ST_W 7
`define CSC_ST_QUAL 7'h01
`define CSC_ST_FAST 7'h02
`define CSC_ST_MAINT 7'h04
`define CSC_ST_DONE 7'h08
`define CSC_ST_ABSENT 7'h10
`define CSC_ST_SLEEP 7'h20
`define CSC_ST_PROBE 7'h40

// Lamp modes
`define CSC_LAMP_FLASH 2'h0
`define CSC_LAMP_LOW 2'h1
`define CSC_LAMP_HIZ 2'h2

// Timer width
`define CSC_TMR_W 48

`endif

// ### rtl/csc_timebase.v
`timescale 1ns/1ns
`default_nettype none
`include "csc_regs.vh"

module csc_timebase #(
   parameter [31:0] SEC_CYCLES = `CSC_CLK_HZ / `CSC_FLASH_HZ,
   parameter [31:0] PULSE_CYCLES = `CSC_TRICKLE_PULSE_US * `CSC_CLK_MHZ,
   parameter [4:0] SAMPLE_SECS = `CSC_SAMPLE_S
) (
   input wire sys_clk, // System clock
   input wire rst, // Synchronous reset
   input wire run, // Oscillator running
   output reg flash, // Lamp flash phase, 1 Hz
   output reg trickle_on, // Trickle pulse window, 1 Hz
   output reg sample_tick // One pulse per sampling interval
);
   reg [31:0] cnt;
   reg [4:0] secs;

   // Stopped oscillator restarts from phase zero, like a grounded RC pin
   always @(posedge sys_clk) begin
      if (rst || !run) begin
         cnt <= 32'h0;
         secs <= 5'h0;
         flash <= 1'b0;
         trickle_on <= 1'b0;
         sample_tick <= 1'b0;
      end else begin
         sample_tick <= 1'b0;
         if (cnt == SEC_CYCLES - 32'h1) begin
            cnt <= 32'h0;
            if (secs == SAMPLE_SECS - 5'h1) begin
               secs <= 5'h0;
               sample_tick <= 1'b1;
            end else begin
               secs <= secs + 5'h1;
            end
         end else begin
            cnt <= cnt + 32'h1;
         end
         flash <= (cnt < (SEC_CYCLES >> 1));
         trickle_on <= (cnt < PULSE_CYCLES);
      end
   end
endmodule

`default_nettype wire

// ### rtl/csc_timer.v
`timescale 1ns/1ns
`default_nettype none
`include "csc_regs.vh"

module csc_timer #(
   parameter [`CSC_TMR_W-1:0] MTO_CYCLES = 48'h1000
) (
   input wire sys_clk, // System clock
   input wire rst, // Synchronous reset
   input wire clear, // Start of a new fast-charge cycle
   input wire run, // Count while high up to the timeout, where it holds; hold while low
   output reg holdoff_done, // Hold-off period elapsed
   output reg expired // Charge timeout reached
);
   localparam [`CSC_TMR_W-1:0] HOLDOFF = MTO_CYCLES / `CSC_HOLDOFF_DIV;
   reg [`CSC_TMR_W-1:0] cnt;

   // Pausing keeps the count so a suspended charge resumes in place
   always @(posedge sys_clk) begin
      if (rst || clear) begin
         cnt <= {`CSC_TMR_W{1'b0}};
         holdoff_done <= 1'b0;
         expired <= 1'b0;
      end else begin
         if (run && cnt != MTO_CYCLES) begin
            cnt <= cnt + 48'h1;
         end
         holdoff_done <= (cnt >= HOLDOFF);
         expired <= (cnt >= MTO_CYCLES);
      end
   end
endmodule

`default_nettype wire

// ### tb/charge_status_sleep_control_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "csc_regs.vh"
module charge_status_sleep_control_bench;
   logic sys_clk, rst, lith, cold, hot, cut, cmin, over, lbat, rise, pres;
   wire sl, mcv, lamp_o, lamp_oe, drive, tp_o, tp_oe, smp, lamp, tp;
   wire [`CSC_ST_W-1:0] st;
   int bad_count, compares, n;
   csc_ctrl #(.SEC_CYCLES(100), .PULSE_CYCLES(10), .MTO_CYCLES(48'd3200)) dut (
      .sys_clk(sys_clk), .rst(rst), .chem_lithium(lith), .cell_above_sleep(sl),
      .cell_above_mcv(mcv), .cell_below_lbat(lbat), .current_over_limit(over),
      .current_below_min(cmin), .temp_cutoff(cut), .hot_fault(hot), .cold_fault(cold),
      .temp_rise_detect(rise), .status_lamp_out(lamp_o), .status_lamp_oe(lamp_oe),
      .switch_drive_out(drive), .timer_program_out(tp_o), .timer_program_oe(tp_oe),
      .temp_sample_out(smp), .charge_state(st));
   csc_far far (.sys_clk(sys_clk), .present(pres), .drive(drive), .lamp_out(lamp_o),
      .lamp_oe(lamp_oe), .tp_out(tp_o), .tp_oe(tp_oe), .lamp_pin(lamp), .tp_pin(tp),
      .above_sleep(sl), .above_mcv(mcv));
   task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge sys_clk);
   endtask
   // Bounded wait; a miss ends the run
   task automatic wait_st(input logic [6:0] s, input int lim);
      n = 0;
      while (st !== s && n < lim) begin
         cyc(1);
         n++;
      end
      chk("state", st, s);
      if (st !== s)
         stop_test();
   endtask
   task automatic start(input logic l, input logic p);
      {lith, cold, hot, cut, cmin, over, lbat, rise, pres} = {l, 7'h00, p};
      rst = 1;
      cyc(20);
      rst = 0;
   endtask
   task automatic t_qual();
      int on = 0;
      int dr = 0;
      start(1, 1);
      cold = 1;
      cyc(2);
      chk("state", st, `CSC_ST_QUAL);
      repeat (100) begin
         cyc(1);
         on += !lamp;
         dr += drive;
      end
      chk("lamp low", on, 50);
      chk("trickle", dr, 10);
      $display("qual test end");
   endtask
   task automatic t_fast();
      int dr = 0;
      start(1, 1);
      cmin = 1;
      over = 1;
      cyc(2);
      chk("state", st, `CSC_ST_FAST);
      chk("lamp", lamp, 0);
      chk("drive", drive, 0);
      over = 0;
      cyc(40);
      chk("drive", drive, 1);
      chk("state", st, `CSC_ST_FAST);
      wait_st(`CSC_ST_DONE, 100);
      chk("lamp", lamp, 1);
      repeat (100) begin
         cyc(1);
         dr += drive;
      end
      chk("drive", dr, 0);
      $display("fast test end");
   endtask
   task automatic t_fault();
      start(1, 1);
      {cold, hot} = 2'b11;
      cyc(2);
      chk("state", st, `CSC_ST_DONE);
      start(1, 1);
      cyc(2);
      hot = 1;
      cyc(5);
      chk("state", st, `CSC_ST_FAST);
      {cold, hot} = 2'b10;
      cyc(1);
      chk("state", st, `CSC_ST_QUAL);
      cold = 0;
      cyc(1);
      chk("state", st, `CSC_ST_FAST);
      cut = 1;
      cyc(1);
      chk("state", st, `CSC_ST_DONE);
      chk("lamp", lamp, 1);
      $display("fault test end");
   endtask
   task automatic t_timeout();
      int s = 0;
      start(0, 1);
      repeat (3000) begin
         cyc(1);
         s += smp;
      end
      chk("samples", s, 1);
      chk("state", st, `CSC_ST_FAST);
      wait_st(`CSC_ST_DONE, 400);
      $display("timeout test end");
   endtask
   task automatic t_maint();
      start(0, 1);
      rise = 1;
      wait_st(`CSC_ST_MAINT, 1700);
      chk("lamp", lamp, 0);
      hot = 1;
      cyc(1);
      chk("state", st, `CSC_ST_DONE);
      chk("lamp", lamp, 1);
      $display("maint test end");
   endtask
   task automatic t_sleep();
      start(1, 0);
      wait_st(`CSC_ST_SLEEP, 50);
      cyc(1);
      chk("sleep pins", {lamp, drive, tp}, 3'h4);
      wait_st(`CSC_ST_PROBE, 100);
      chk("drive", drive, 1);
      wait_st(`CSC_ST_SLEEP, 100);
      pres = 1;
      wait_st(`CSC_ST_FAST, 200);
      $display("sleep test end");
   endtask
   initial begin
      sys_clk = 0;
      forever #10 sys_clk = ~sys_clk;
   end
   initial begin
      bad_count = 0;
      compares = 0;
      t_qual();
      t_fast();
      t_fault();
      t_timeout();
      t_maint();
      t_sleep();
      stop_test();
   end
endmodule
`default_nettype wire

// ### tb/csc_ctrl_chk.sv
`timescale 1ns/1ns
`default_nettype none
`include "csc_regs.vh"
module csc_ctrl_chk (
   input wire logic sys_clk, // Clock
   input wire logic rst, // Reset
   input wire logic cell_above_sleep, // Over sleep level
   input wire logic cell_above_mcv, // Over max level
   input wire logic temp_cutoff, // Too hot
   input wire logic cold_fault, // Too cold
   input wire logic status_lamp_out, // Lamp data
   input wire logic status_lamp_oe, // Lamp enable
   input wire logic switch_drive_out, // Drive
   input wire logic timer_program_oe, // Timer pin ground
   input wire logic [`CSC_ST_W-1:0] charge_state // State
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   a_fast_lamp_low: assert property (charge_state == `CSC_ST_FAST |->
      status_lamp_oe && !status_lamp_out) else $error("lamp not low in fast charge");
   a_sleep_pins: assert property (charge_state == `CSC_ST_SLEEP |->
      !status_lamp_oe && !switch_drive_out && timer_program_oe) else $error("sleep pins wrong");
   a_idle_lamp_off: assert property (|(charge_state & 7'h18) |-> !status_lamp_oe)
      else $error("lamp driven when idle");
   a_state_onehot: assert property ($onehot(charge_state))
      else $error("state not one-hot");
   a_sleep_entry: assert property (cell_above_sleep |=> charge_state == `CSC_ST_SLEEP)
      else $error("no sleep above threshold");
   a_cutoff_stop: assert property (charge_state == `CSC_ST_FAST && temp_cutoff
      && !cell_above_sleep |=> charge_state == `CSC_ST_DONE && !status_lamp_oe)
      else $error("cutoff did not stop charge");
   a_cold_suspend: assert property (charge_state == `CSC_ST_FAST && cold_fault
      && !temp_cutoff && !cell_above_sleep |=> charge_state inside {`CSC_ST_QUAL, `CSC_ST_DONE})
      else $error("cold did not suspend");
   a_wake_probe: assert property (charge_state == `CSC_ST_SLEEP && !cell_above_sleep
      && !cell_above_mcv |=> charge_state == `CSC_ST_PROBE) else $error("no wake");
endmodule
bind csc_ctrl csc_ctrl_chk chk_i (.sys_clk(sys_clk), .rst(rst),
   .cell_above_sleep(cell_above_sleep), .cell_above_mcv(cell_above_mcv),
   .temp_cutoff(temp_cutoff), .cold_fault(cold_fault), .status_lamp_out(status_lamp_out),
   .status_lamp_oe(status_lamp_oe), .switch_drive_out(switch_drive_out),
   .timer_program_oe(timer_program_oe), .charge_state(charge_state));
`default_nettype wire

// ### tb/csc_far.sv
`timescale 1ns/1ns
`default_nettype none
module csc_far (
   input wire logic sys_clk, // Clock
   input wire logic present, // Battery attached
   input wire logic drive, // Switching drive
   input wire logic lamp_out, // Lamp data
   input wire logic lamp_oe, // Lamp enable
   input wire logic tp_out, // Timer pin data
   input wire logic tp_oe, // Timer pin enable
   output wire logic lamp_pin, // Lamp node
   output wire logic tp_pin, // Timer node
   output wire logic above_sleep, // Node over sleep level
   output wire logic above_mcv // Node over max level
);
   logic [5:0] volts = 6'h00;
   logic osc = 1'b0;
   // Output node charged by drive, decays slowly with nothing attached
   always @(posedge sys_clk) begin
      if (present)
         volts <= 6'h00;
      else if (drive)
         volts <= 6'h3F;
      else if (volts != 6'h00)
         volts <= volts - 6'h01;
      osc <= !osc;
   end
   // Lamp has a pull-up; released timer pin toggles every clock, never holds a level
   assign lamp_pin = lamp_oe ? lamp_out : 1'b1;
   assign tp_pin = tp_oe ? tp_out : osc;
   assign above_sleep = volts > 6'h28;
   assign above_mcv = volts > 6'h14;
endmodule
`default_nettype wire
